// >>> rtl/rps_params.svh
// rps_params.svh: offsets, field positions, reset values and frame lengths
// of the protocol select register bank.
// assumes it is included by bare name from the package and the modules.
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH

// register offsets on the host port
`define RPS_ADDR_W 5
`define RPS_ADDR_PROTO 5'h01
`define RPS_ADDR_TYPEB 5'h02
`define RPS_ADDR_TYPEA 5'h03

// reset values
`define RPS_PROTO_RST 8'h02
`define RPS_TYPEB_RST 8'h00
`define RPS_TYPEA_RST 8'h00

// protocol select fields
`define RPS_PS_NO_CRC 7
`define RPS_PS_DIRECT 6
`define RPS_PS_READER 5
`define RPS_PS_CODE_HI 4

// type b option fields
`define RPS_TB_GUARD_HI 7
`define RPS_TB_GUARD_LO 5
`define RPS_TB_END_LOW 4
`define RPS_TB_START_HIGH 3
`define RPS_TB_START_LOW 2
`define RPS_TB_GUARD_LAST 1
`define RPS_TB_MASK 8'hFE

// type a option fields
`define RPS_TA_SPLIT 7
`define RPS_TA_RATE_HI 6
`define RPS_TA_RATE_LO 5
`define RPS_TA_TX_PAR 4
`define RPS_TA_RX_PAR 3
`define RPS_TA_MASK 8'hF8

// frame lengths in elementary time units
`define RPS_ETU_LOW_SHORT 4'd10
`define RPS_ETU_LOW_LONG 4'd11
`define RPS_ETU_HIGH_SHORT 2'd2
`define RPS_ETU_HIGH_LONG 2'd3

`endif

// >>> rtl/rps_pkg.sv
// rps_pkg: types shared by the protocol select register bank.
// assumes rps_params.svh is on the include path.
`include "rps_params.svh"

package rps_pkg;

    // air protocol family
    typedef enum logic [2:0] {
        RPS_FAM_VIC1,
        RPS_FAM_VIC2,
        RPS_FAM_PROXA,
        RPS_FAM_PROXB,
        RPS_FAM_PROP,
        RPS_FAM_UNSUP
    } rps_family_e;

    // bit rates on air
    typedef enum logic [3:0] {
        RPS_RATE_6K62,
        RPS_RATE_26K48,
        RPS_RATE_6K67,
        RPS_RATE_26K69,
        RPS_RATE_106K,
        RPS_RATE_212K,
        RPS_RATE_424K,
        RPS_RATE_848K,
        RPS_RATE_NONE
    } rps_rate_e;

    // decoded protocol configuration
    typedef struct packed {
        rps_family_e family;
        rps_rate_e rx_rate;
        rps_rate_e tx_rate;
        logic one_of_256;
        logic crc_expected;
        logic direct_mode1;
        logic supported;
        logic tx_final_even;
        logic rx_final_even;
    } rps_proto_s;

    // type b transmit framing
    typedef struct packed {
        logic [2:0] guard_etu;
        logic [3:0] end_low_etu;
        logic [1:0] start_high_etu;
        logic [3:0] start_low_etu;
        logic guard_after_last;
    } rps_typeb_s;

    // two-bit proximity rate code, used for receive and transmit rates
    function automatic rps_rate_e rps_prox_rate(input logic [1:0] code);
        rps_rate_e r;
        r = RPS_RATE_106K;
        case (code)
            2'h1: r = RPS_RATE_212K;
            2'h2: r = RPS_RATE_424K;
            2'h3: r = RPS_RATE_848K;
            default: r = RPS_RATE_106K;
        endcase
        return r;
    endfunction : rps_prox_rate

endpackage : rps_pkg

// >>> rtl/rps_proto_decode.sv
// rps_proto_decode: turns the five-bit protocol code into family and rate.
// assumes a stable code from the register bank; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module rps_proto_decode
    import rps_pkg::*;
(
    input wire logic [4:0] code_i,
    output rps_family_e family_o,
    output rps_rate_e rate_o,
    output logic one_of_256_o,
    output logic high_rate_o
);

    // family from the upper code bits, detail from the lower two
    always_comb begin
        family_o = RPS_FAM_UNSUP;
        rate_o = RPS_RATE_NONE;
        one_of_256_o = 1'b0;
        high_rate_o = 1'b0;
        case (code_i[4:2])
            3'h0: begin
                family_o = RPS_FAM_VIC1;
                rate_o = code_i[1] ? RPS_RATE_26K48 : RPS_RATE_6K62;
                one_of_256_o = code_i[0];
            end
            3'h1: begin
                family_o = RPS_FAM_VIC2;
                rate_o = code_i[1] ? RPS_RATE_26K69 : RPS_RATE_6K67;
                one_of_256_o = code_i[0];
            end
            3'h2: begin
                family_o = RPS_FAM_PROXA;
                rate_o = rps_prox_rate(code_i[1:0]);
                high_rate_o = |code_i[1:0];
            end
            3'h3: begin
                family_o = RPS_FAM_PROXB;
                rate_o = rps_prox_rate(code_i[1:0]);
                high_rate_o = |code_i[1:0];
            end
            3'h6: begin
                // only the two upper rate codes exist in this group
                if (code_i[1]) begin
                    family_o = RPS_FAM_PROP;
                    rate_o = code_i[0] ? RPS_RATE_424K : RPS_RATE_212K;
                end
            end
            default: begin
                family_o = RPS_FAM_UNSUP;
            end
        endcase
    end

endmodule : rps_proto_decode

`default_nettype wire

// >>> rtl/rps_typeb_timing.sv
// rps_typeb_timing: type b transmit framing lengths from the option byte.
// assumes the option byte comes from the register bank; combinational.
`timescale 1ns/1ps
`default_nettype none
`include "rps_params.svh"

module rps_typeb_timing
    import rps_pkg::*;
(
    input wire logic [7:0] opt_i,
    input wire logic is_typeb_i,
    output rps_typeb_s frame_o
);

    // guard time only exists on type b transmit, so it is zero elsewhere
    always_comb begin
        frame_o.guard_etu = is_typeb_i ? opt_i[`RPS_TB_GUARD_HI:`RPS_TB_GUARD_LO] : 3'h0;
        frame_o.end_low_etu = opt_i[`RPS_TB_END_LOW] ?
            `RPS_ETU_LOW_LONG : `RPS_ETU_LOW_SHORT;
        frame_o.start_high_etu = opt_i[`RPS_TB_START_HIGH] ?
            `RPS_ETU_HIGH_LONG : `RPS_ETU_HIGH_SHORT;
        frame_o.start_low_etu = opt_i[`RPS_TB_START_LOW] ?
            `RPS_ETU_LOW_LONG : `RPS_ETU_LOW_SHORT;
        frame_o.guard_after_last = opt_i[`RPS_TB_GUARD_LAST];
    end

endmodule : rps_typeb_timing

`default_nettype wire

// >>> rtl/rps_regs.sv
// rps_regs: protocol select, type b framing and type a rate/parity registers
// of the reader front end, with the decoded configuration they drive.
// assumes the host port logic runs on CLOCK_I; EN_I is an asynchronous pin.
//
// Summary of operation
// - protocol select resets to 0x02 on enable-low
// - bit 7 set means no receive crc
// - bit 6 picks direct mode 0 or 1
// - codes 0-3: single subcarrier vicinity, rate, coding
// - codes 4-7: double subcarrier vicinity, rate, coding
// - codes 8-11: type a, 106 to 848
// - codes 12-15: type b, 106 to 848
// - type a options also cleared by protocol writes
// - bits 7:5 give type b guard units
// - bit 4: end low length 11 or 10
// - bit 3: start high length 3 or 2
// - bit 2: start low length 11 or 10
// - bit 1: guard after final byte too
// - type a bit 7 splits transmit rate; code applies it only in high-rate type a or b modes
// - bits 6:5 pick transmit rate 106 to 848
// - bit 4: odd transmit parity, final even
// - bit 3: odd receive parity, final even; code applies it only in type a at 212 to 848
`timescale 1ns/1ps
`default_nettype none
`include "rps_params.svh"

module rps_regs
    import rps_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RESETN_I,
    input wire logic EN_I,
    input wire logic HOST_WR_I,
    input wire logic HOST_RD_I,
    input wire logic [`RPS_ADDR_W-1:0] HOST_ADDR_I,
    input wire logic [7:0] HOST_WDATA_I,
    output logic [7:0] HOST_RDATA_O,
    output logic HOST_RVALID_O,
    output rps_proto_s CFG_PROTO_O,
    output rps_typeb_s CFG_TYPEB_O
);

    logic en_meta;
    logic en_sync;
    logic en_low;
    logic [7:0] protocol_select;
    logic [7:0] typeb_tx_framing_options;
    logic [7:0] typea_rate_parity_options;
    logic wr_proto;
    logic wr_typeb;
    logic wr_typea;
    rps_family_e dec_family;
    rps_rate_e dec_rate;
    logic dec_one_of_256;
    logic dec_high_rate;
    rps_typeb_s next_typeb;
    rps_proto_s next_proto;
    logic [7:0] next_rdata;

    // enable pin passes two flip-flops before anything looks at it
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end else begin
            en_meta <= EN_I;
            en_sync <= en_meta;
        end
    end

    // enable low acts as a synchronous reset of the whole bank
    assign en_low = !en_sync;

    // write strobes per register; unmapped writes are dropped
    assign wr_proto = HOST_WR_I && (HOST_ADDR_I == `RPS_ADDR_PROTO);
    assign wr_typeb = HOST_WR_I && (HOST_ADDR_I == `RPS_ADDR_TYPEB);
    assign wr_typea = HOST_WR_I && (HOST_ADDR_I == `RPS_ADDR_TYPEA);

    // protocol select; bit 5 is stored as written and never steers logic
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            protocol_select <= `RPS_PROTO_RST;
        end else if (en_low) begin
            protocol_select <= `RPS_PROTO_RST;
        end else if (wr_proto) begin
            protocol_select <= HOST_WDATA_I;
        end
    end

    // type b options survive protocol writes
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            typeb_tx_framing_options <= `RPS_TYPEB_RST;
        end else if (en_low) begin
            typeb_tx_framing_options <= `RPS_TYPEB_RST;
        end else if (wr_typeb) begin
            typeb_tx_framing_options <= HOST_WDATA_I & `RPS_TB_MASK;
        end
    end

    // type a options fall back to zero whenever the protocol is rewritten
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            typea_rate_parity_options <= `RPS_TYPEA_RST;
        end else if (en_low || wr_proto) begin
            typea_rate_parity_options <= `RPS_TYPEA_RST;
        end else if (wr_typea) begin
            typea_rate_parity_options <= HOST_WDATA_I & `RPS_TA_MASK;
        end
    end

    rps_proto_decode u_decode (
        .code_i(protocol_select[`RPS_PS_CODE_HI:0]),
        .family_o(dec_family),
        .rate_o(dec_rate),
        .one_of_256_o(dec_one_of_256),
        .high_rate_o(dec_high_rate)
    );

    rps_typeb_timing u_typeb (
        .opt_i(typeb_tx_framing_options),
        .is_typeb_i(dec_family == RPS_FAM_PROXB),
        .frame_o(next_typeb)
    );

    // decoded configuration; transmit rate follows receive unless split
    always_comb begin
        next_proto.family = dec_family;
        next_proto.rx_rate = dec_rate;
        next_proto.one_of_256 = dec_one_of_256;
        next_proto.crc_expected = !protocol_select[`RPS_PS_NO_CRC];
        next_proto.direct_mode1 = protocol_select[`RPS_PS_DIRECT];
        next_proto.supported = (dec_family != RPS_FAM_UNSUP);
        next_proto.tx_rate = dec_rate;
        // split only counts in high-rate type a or b modes
        if (typea_rate_parity_options[`RPS_TA_SPLIT] && dec_high_rate) begin
            next_proto.tx_rate = rps_prox_rate(
                typea_rate_parity_options[`RPS_TA_RATE_HI:`RPS_TA_RATE_LO]);
        end
        next_proto.tx_final_even = typea_rate_parity_options[`RPS_TA_TX_PAR]
            && (dec_family == RPS_FAM_PROXA);
        next_proto.rx_final_even = typea_rate_parity_options[`RPS_TA_RX_PAR]
            && (dec_family == RPS_FAM_PROXA) && dec_high_rate;
    end

    // outputs are registered so the datapaths see glitch-free settings
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            CFG_PROTO_O <= '0;
            CFG_TYPEB_O <= '0;
        end else begin
            CFG_PROTO_O <= next_proto;
            CFG_TYPEB_O <= next_typeb;
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        case (HOST_ADDR_I)
            `RPS_ADDR_PROTO: next_rdata = protocol_select;
            `RPS_ADDR_TYPEB: next_rdata = typeb_tx_framing_options;
            `RPS_ADDR_TYPEA: next_rdata = typea_rate_parity_options;
            default: next_rdata = 8'h00;
        endcase
    end

    // read answer one cycle after the strobe, data held until next read
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            HOST_RDATA_O <= 8'h00;
            HOST_RVALID_O <= 1'b0;
        end else begin
            HOST_RVALID_O <= HOST_RD_I;
            if (HOST_RD_I) begin
                HOST_RDATA_O <= next_rdata;
            end
        end
    end

    // checks on the bank, all in the main clock domain
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RESETN_I);

    sequence s_wr_proto_live;
        wr_proto && !en_low;
    endsequence

    sequence s_wr_typeb_end_long;
        wr_typeb && !en_low && HOST_WDATA_I[`RPS_TB_END_LOW];
    endsequence

    property p_en_reset;
        en_low |=> protocol_select == `RPS_PROTO_RST
            && typeb_tx_framing_options == `RPS_TYPEB_RST
            ##1 CFG_PROTO_O.rx_rate == RPS_RATE_26K48;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enable low did not reset bank");

    property p_crc;
        1 |=> CFG_PROTO_O.crc_expected == !$past(protocol_select[`RPS_PS_NO_CRC]);
    endproperty
    a_crc: assert property (p_crc) else $error("crc expectation wrong");

    property p_direct;
        1 |=> CFG_PROTO_O.direct_mode1 == $past(protocol_select[`RPS_PS_DIRECT]);
    endproperty
    a_direct: assert property (p_direct) else $error("direct mode variant wrong");

    property p_vic_single;
        protocol_select[4:2] == 3'h0 |=> CFG_PROTO_O.family == RPS_FAM_VIC1
            && CFG_PROTO_O.one_of_256 == $past(protocol_select[0]);
    endproperty
    a_vic_single: assert property (p_vic_single) else $error("single vicinity decode wrong");

    property p_typea_rate;
        protocol_select[4:2] == 3'h2 |=> CFG_PROTO_O.family == RPS_FAM_PROXA
            && CFG_PROTO_O.rx_rate == rps_prox_rate($past(protocol_select[1:0]));
    endproperty
    a_typea_rate: assert property (p_typea_rate) else $error("type a rate wrong");

    property p_typeb_rate;
        protocol_select[4:0] == 5'h0F |=> CFG_PROTO_O.family == RPS_FAM_PROXB
            && CFG_PROTO_O.rx_rate == RPS_RATE_848K;
    endproperty
    a_typeb_rate: assert property (p_typeb_rate) else $error("type b rate wrong");

    property p_unsup;
        protocol_select[4] && protocol_select[4:1] != 4'hD |=> !CFG_PROTO_O.supported;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unsupported code accepted");

    property p_typea_clear;
        s_wr_proto_live |=> typea_rate_parity_options == 8'h00
            && typeb_tx_framing_options == $past(typeb_tx_framing_options);
    endproperty
    a_typea_clear: assert property (p_typea_clear) else $error("option clear on write wrong");

    property p_end_long;
        s_wr_typeb_end_long |=> ##1 CFG_TYPEB_O.end_low_etu == `RPS_ETU_LOW_LONG;
    endproperty
    a_end_long: assert property (p_end_long) else $error("end low length not 11");

    property p_tx_split;
        typea_rate_parity_options[`RPS_TA_SPLIT] && dec_high_rate |=>
            CFG_PROTO_O.tx_rate == rps_prox_rate($past(typea_rate_parity_options[6:5]));
    endproperty
    a_tx_split: assert property (p_tx_split) else $error("split transmit rate wrong");

    property p_tx_parity;
        dec_family == RPS_FAM_PROXA |=>
            CFG_PROTO_O.tx_final_even == $past(typea_rate_parity_options[`RPS_TA_TX_PAR]);
    endproperty
    a_tx_parity: assert property (p_tx_parity) else $error("transmit parity mode wrong");

    property p_vic_double;
        protocol_select[4:2] == 3'h1 |=> CFG_PROTO_O.family == RPS_FAM_VIC2
            && CFG_PROTO_O.one_of_256 == $past(protocol_select[0])
            && CFG_PROTO_O.rx_rate == ($past(protocol_select[1]) ? RPS_RATE_26K69 : RPS_RATE_6K67);
    endproperty
    a_vic_double: assert property (p_vic_double) else $error("double vicinity decode wrong");

    property p_en_typea;
        en_low |=> typea_rate_parity_options == `RPS_TYPEA_RST;
    endproperty
    a_en_typea: assert property (p_en_typea) else $error("enable low kept type a options");

    // guard units must vanish one cycle after the family leaves type b
    property p_guard;
        1 |=> CFG_TYPEB_O.guard_etu == ($past(dec_family == RPS_FAM_PROXB) ?
            $past(typeb_tx_framing_options[`RPS_TB_GUARD_HI:`RPS_TB_GUARD_LO]) : 3'h0);
    endproperty
    a_guard: assert property (p_guard) else $error("guard units wrong");

    property p_start_high;
        1 |=> CFG_TYPEB_O.start_high_etu == ($past(typeb_tx_framing_options[`RPS_TB_START_HIGH])
            ? `RPS_ETU_HIGH_LONG : `RPS_ETU_HIGH_SHORT);
    endproperty
    a_start_high: assert property (p_start_high) else $error("start high length wrong");

    property p_start_low;
        1 |=> CFG_TYPEB_O.start_low_etu == ($past(typeb_tx_framing_options[`RPS_TB_START_LOW])
            ? `RPS_ETU_LOW_LONG : `RPS_ETU_LOW_SHORT);
    endproperty
    a_start_low: assert property (p_start_low) else $error("start low length wrong");

    property p_guard_last;
        1 |=> CFG_TYPEB_O.guard_after_last == $past(typeb_tx_framing_options[`RPS_TB_GUARD_LAST]);
    endproperty
    a_guard_last: assert property (p_guard_last) else $error("final guard flag wrong");

    property p_no_split;
        !(typea_rate_parity_options[`RPS_TA_SPLIT] && dec_high_rate) |=> CFG_PROTO_O.tx_rate == CFG_PROTO_O.rx_rate;
    endproperty
    a_no_split: assert property (p_no_split) else $error("transmit rate split outside high rate");

    property p_rx_parity;
        1 |=> CFG_PROTO_O.rx_final_even == $past(typea_rate_parity_options[`RPS_TA_RX_PAR]
            && dec_family == RPS_FAM_PROXA && dec_high_rate);
    endproperty
    a_rx_parity: assert property (p_rx_parity) else $error("receive parity mode wrong");

endmodule : rps_regs

`default_nettype wire

// >>> test/rps_host_model.sv
// rps_host_model: host side of the register port, single byte writes and reads.
// assumes the bank samples on the rising edge; this side moves on the falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "rps_params.svh"

module rps_host_model (
    input wire logic clk_i,
    output logic wr_o,
    output logic rd_o,
    output logic [`RPS_ADDR_W-1:0] addr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    // idle bus: strobes low, address and data parked away from the last value
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 5'h1F;
        wdata_o = 8'hA5;
    end

    // one strobe cycle per byte; the reserved mode bit is sent clear on protocol select writes only
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = (a == `RPS_ADDR_PROTO) ? (d & 8'hDF) : d;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~wdata_o;
    endtask : wr_reg

    // answer is due one edge after the strobe, so it is taken one cycle later
    task automatic rd_reg(input logic [4:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_i);
        rd_o = 1'b1;
        addr_o = a;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        ok = rvalid_i;
        d = rdata_i;
    endtask : rd_reg
endmodule : rps_host_model
`default_nettype wire

// >>> test/tb.sv
// tb: self-checking bench for the protocol select register bank.
// assumes rps_pkg, rps_regs and rps_host_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "rps_params.svh"

module tb
    import rps_pkg::*;
;
    logic CLOCK_I = 1'b0;
    logic RESETN_I = 1'b0;
    logic EN_I = 1'b1;
    logic host_wr, host_rd, host_rvalid;
    logic [4:0] host_addr;
    logic [7:0] host_wdata, host_rdata;
    rps_proto_s cfg;
    rps_typeb_s tb_cfg;
    int mismatches = 0;
    int compares = 0;

    // 40 MHz clock
    always #12.5 CLOCK_I = ~CLOCK_I;

    rps_regs dut_u (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .EN_I(EN_I),
        .HOST_WR_I(host_wr), .HOST_RD_I(host_rd), .HOST_ADDR_I(host_addr),
        .HOST_WDATA_I(host_wdata), .HOST_RDATA_O(host_rdata),
        .HOST_RVALID_O(host_rvalid), .CFG_PROTO_O(cfg), .CFG_TYPEB_O(tb_cfg));

    rps_host_model host_u (.clk_i(CLOCK_I), .wr_o(host_wr), .rd_o(host_rd),
        .addr_o(host_addr), .wdata_o(host_wdata), .rdata_i(host_rdata),
        .rvalid_i(host_rvalid));

    // verdict and end of run
    task automatic test_done;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    // a missing answer strobe ends the run at once
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        host_u.rd_reg(a, d, ok);
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR t=%0t got=%0h exp=1", $time, ok);
            test_done();
        end
        chk(d, e);
    endtask : rd_chk

    // config outputs follow one edge after the write lands
    task automatic wrs(input logic [4:0] a, input logic [7:0] d);
        host_u.wr_reg(a, d);
        @(negedge CLOCK_I);
    endtask : wrs

    // expected family, receive rate and support of a protocol code
    function automatic void exp_dec(input logic [4:0] c, output rps_family_e f,
                                    output rps_rate_e r, output logic s);
        rps_rate_e px [4] = '{RPS_RATE_106K, RPS_RATE_212K, RPS_RATE_424K, RPS_RATE_848K};
        s = 1'b1;
        f = RPS_FAM_UNSUP;
        r = RPS_RATE_NONE;
        if (c < 5'h04) begin
            f = RPS_FAM_VIC1;
            r = c[1] ? RPS_RATE_26K48 : RPS_RATE_6K62;
        end else if (c < 5'h08) begin
            f = RPS_FAM_VIC2;
            r = c[1] ? RPS_RATE_26K69 : RPS_RATE_6K67;
        end else if (c < 5'h10) begin
            f = c[2] ? RPS_FAM_PROXB : RPS_FAM_PROXA;
            r = px[c[1:0]];
        end else if (c[4:1] == 4'hD) begin
            f = RPS_FAM_PROP;
            r = c[0] ? RPS_RATE_424K : RPS_RATE_212K;
        end else begin
            s = 1'b0;
        end
    endfunction : exp_dec

    // defaults after reset, unmapped places read zero and ignore writes
    task automatic t_reset;
        rd_chk(`RPS_ADDR_PROTO, `RPS_PROTO_RST);
        rd_chk(`RPS_ADDR_TYPEB, `RPS_TYPEB_RST);
        rd_chk(`RPS_ADDR_TYPEA, `RPS_TYPEA_RST);
        chk(cfg.rx_rate, RPS_RATE_26K48);
        host_u.wr_reg(5'h04, 8'hFF);
        rd_chk(5'h04, 8'h00);
        rd_chk(5'h00, 8'h00);
        rd_chk(`RPS_ADDR_PROTO, `RPS_PROTO_RST);
    endtask : t_reset

    // every protocol code, supported or not
    task automatic t_codes;
        rps_family_e f;
        rps_rate_e r;
        logic s;
        for (int i = 0; i < 32; i++) begin
            wrs(`RPS_ADDR_PROTO, {3'h0, i[4:0]});
            exp_dec(i[4:0], f, r, s);
            chk(cfg.family, f);
            chk(cfg.rx_rate, r);
            chk(cfg.tx_rate, r);
            chk(cfg.supported, s);
            chk(cfg.crc_expected, 1'b1);
            if (i < 8) begin
                chk(cfg.one_of_256, i[0]);
            end
        end
    endtask : t_codes

    // crc and direct-mode bits in all four combinations
    task automatic t_bits;
        logic [7:0] d;
        for (int j = 0; j < 4; j++) begin
            d = {j[1:0], 6'h08};
            wrs(`RPS_ADDR_PROTO, d);
            chk(cfg.crc_expected, !d[7]);
            chk(cfg.direct_mode1, d[6]);
            rd_chk(`RPS_ADDR_PROTO, d);
        end
    endtask : t_bits

    // split transmit rate and parity, then clearing by a protocol write
    task automatic t_typea;
        rps_family_e f;
        rps_rate_e r;
        logic s;
        for (int k = 0; k < 4; k++) begin
            wrs(`RPS_ADDR_PROTO, 8'h0B);
            wrs(`RPS_ADDR_TYPEA, {1'b1, k[1:0], 5'h18});
            exp_dec({3'h2, k[1:0]}, f, r, s);
            chk(cfg.tx_rate, r);
            chk(cfg.rx_rate, RPS_RATE_848K);
            chk(cfg.tx_final_even, 1'b1);
            chk(cfg.rx_final_even, 1'b1);
            rd_chk(`RPS_ADDR_TYPEA, {1'b1, k[1:0], 5'h18});
        end
        wrs(`RPS_ADDR_PROTO, 8'h08);
        rd_chk(`RPS_ADDR_TYPEA, 8'h00);
        chk(cfg.tx_final_even, 1'b0);
        wrs(`RPS_ADDR_TYPEA, 8'hFF);
        chk(cfg.tx_rate, RPS_RATE_106K);
        chk(cfg.rx_final_even, 1'b0);
        chk(cfg.tx_final_even, 1'b1);
        rd_chk(`RPS_ADDR_TYPEA, `RPS_TA_MASK);
    endtask : t_typea

    // type b framing lengths, guard units and survival across protocol writes
    task automatic t_typeb;
        wrs(`RPS_ADDR_PROTO, 8'h0C);
        for (int g = 0; g < 8; g++) begin
            wrs(`RPS_ADDR_TYPEB, {g[2:0], 5'h00});
            chk(tb_cfg.guard_etu, g[2:0]);
            chk(tb_cfg.end_low_etu, `RPS_ETU_LOW_SHORT);
            chk(tb_cfg.start_high_etu, `RPS_ETU_HIGH_SHORT);
            chk(tb_cfg.start_low_etu, `RPS_ETU_LOW_SHORT);
            chk(tb_cfg.guard_after_last, 1'b0);
        end
        wrs(`RPS_ADDR_TYPEB, 8'h1E);
        chk(tb_cfg.end_low_etu, `RPS_ETU_LOW_LONG);
        chk(tb_cfg.start_high_etu, `RPS_ETU_HIGH_LONG);
        chk(tb_cfg.start_low_etu, `RPS_ETU_LOW_LONG);
        chk(tb_cfg.guard_after_last, 1'b1);
        wrs(`RPS_ADDR_TYPEB, 8'hFF);
        wrs(`RPS_ADDR_PROTO, 8'h08);
        rd_chk(`RPS_ADDR_TYPEB, `RPS_TB_MASK);
        chk(tb_cfg.guard_etu, 3'h0);
    endtask : t_typeb

    // enable low resets the bank and refuses writes; then a second power-on reset
    task automatic t_enable;
        wrs(`RPS_ADDR_PROTO, 8'h0D);
        wrs(`RPS_ADDR_TYPEB, 8'h10);
        wrs(`RPS_ADDR_TYPEA, 8'h80);
        EN_I = 1'b0;
        repeat (4) @(negedge CLOCK_I);
        host_u.wr_reg(`RPS_ADDR_PROTO, 8'h0E);
        EN_I = 1'b1;
        repeat (4) @(negedge CLOCK_I);
        rd_chk(`RPS_ADDR_PROTO, `RPS_PROTO_RST);
        rd_chk(`RPS_ADDR_TYPEB, `RPS_TYPEB_RST);
        rd_chk(`RPS_ADDR_TYPEA, `RPS_TYPEA_RST);
        chk(cfg.family, RPS_FAM_VIC1);
        wrs(`RPS_ADDR_PROTO, 8'h0C);
        RESETN_I = 1'b0;
        repeat (2) @(negedge CLOCK_I);
        RESETN_I = 1'b1;
        repeat (4) @(negedge CLOCK_I);
        rd_chk(`RPS_ADDR_PROTO, `RPS_PROTO_RST);
    endtask : t_enable

    // main sequence: reset held for 16 cycles, then each scenario
    initial begin
        repeat (16) @(negedge CLOCK_I);
        RESETN_I = 1'b1;
        repeat (4) @(negedge CLOCK_I);
        t_reset();
        t_codes();
        t_bits();
        t_typea();
        t_typeb();
        t_enable();
        test_done();
    end
endmodule : tb
`default_nettype wire
